/* flag_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// One sticky status bit
module flag_cell (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic hold_i,
  output var  logic flag_o
);
  // Whole state of the cell
  typedef struct packed {
    logic flag;
  } cell_s;

  cell_s q;  // Registered state
  cell_s d;  // Next state

  // Set wins over clear; clear blocked while cause persists
  always_comb begin
    d = q;
    if (set_i) begin
      d.flag = 1'b1;
    end else if (clr_i && !hold_i) begin
      d.flag = 1'b0;
    end
  end

  // State register with clock enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (en_i) begin
      q <= d;
    end
  end

  assign flag_o = q.flag;
endmodule  // flag_cell
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the status path: turns a clear request into a one-cycle strobe
module host_model (
  input  wire logic                   clk_i,
  input  wire logic                   clr_req_i,
  input  wire supervisor_pkg::flags_s clr_mask_i,
  output var  supervisor_pkg::flags_s flag_clr_o
);
  // Strobe launched just after the edge, one cycle wide
  always @(posedge clk_i) begin
    flag_clr_o <= #1 clr_req_i ? clr_mask_i : '0;
  end
endmodule // host_model
`default_nettype wire

/* supervisor_pkg.sv */
`default_nettype none
package supervisor_pkg;
  // Core clock rate
  localparam int CLK_MHZ          = 20;
  // Main-rail short filter time in microseconds
  localparam int SHORT_FILTER_US  = 4000;
  // Reset delay time in microseconds, plain default
  localparam int RESET_DELAY_US   = 10000;
  // Derived cycle counts
  localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
  localparam int RESET_DELAY_CYC  = RESET_DELAY_US * CLK_MHZ;
  // Width of the timing counters
  localparam int CNT_W            = 18;
  // Consecutive undervoltage events that force fail-safe
  localparam logic [2:0] UV_FS_COUNT   = 3'h4;
  // Transceiver fail field value on overtemperature
  localparam logic [1:0] XCVR_FAIL_OT  = 2'h1;
  // Reset values of status and control
  localparam logic [1:0] XCVR_FAIL_RST = 2'h0;
  localparam logic       TX_EN_RST     = 1'b1;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_STOP     = 3'b010,
    MODE_SLEEP    = 3'b011,
    MODE_RESTART  = 3'b100,
    MODE_FAILSAFE = 3'b101
  } mode_e;

  // Comparator and pin levels from the analog side
  typedef struct packed {
    logic       batt_uv;
    logic       highside_uv;
    logic       highside_ov;
    logic       main_warn;
    logic       main_uv;
    logic       main_ov;
    logic       aux_uv;
    logic       xcvr_uv;
    logic       aux_ot;
    logic       ext_ot;
    logic       xcvr_ot;
    logic [3:0] highside_ot;
    logic       failsafe_config_pin;
    logic       wake;
  } cmp_s;

  // Sticky status flags
  typedef struct packed {
    logic       battery_undervoltage_flag;
    logic       highside_supply_uv_flag;
    logic       highside_supply_ov_flag;
    logic       main_rail_warning_flag;
    logic       main_rail_uv_flag;
    logic       repeated_uv_failsafe_flag;
    logic       main_rail_ov_flag;
    logic       main_rail_short_flag;
    logic       failure_flag;
    logic       aux_reg_uv_flag;
    logic       transceiver_supply_uv_flag;
    logic       block_overtemp_flag;
    logic       aux_reg_overtemp_flag;
    logic       ext_reg_overtemp_flag;
    logic [3:0] highside_oc_ot_flags;
  } flags_s;

  localparam int FLAG_W = $bits(flags_s);
endpackage
`default_nettype wire

/* supply_thermal_fault_supervisor.sv */
// What this block does
// - Battery undervoltage sets only its flag, clear after
// - Battery undervoltage disables ext regulator unless kept
// - Battery undervoltage suspends main-rail short protection
// - Battery recovery re-enables disabled functions automatically
// - Highside undervoltage sets only its flag
// - Highside overvoltage sets only its flag
// - Main-rail prewarning sets warning flag only
// - Main-rail undervoltage: reset low, flag, restart
// - Count consecutive undervoltage in init, stop, and normal without battery undervoltage
// - Fourth event: fail-safe, flag; counter clears
// - Main-rail overvoltage always sets flag in init/normal
// - Overvoltage reset, pin one: restart, then normal
// - Overvoltage reset, pin zero: fail-safe, fail outputs
// - Main rail low too long: short, fail-safe
// - Load sharing disables transistor per keep bits
// - Aux and transceiver undervoltage set SPI-clear flags
// - Block overtemperature switches stage off, sets flag
// - Aux or stand-alone ext overtemperature clears enables
// - Load-sharing overtemperature: off, auto back on
// - Transceiver overtemperature: receive only, fail field 01
// - Highside overtemperature: all off, bits cleared, flags
`timescale 1ns/1ps
`default_nettype none
module supply_thermal_fault_supervisor #(
  parameter int SHORT_CYC = supervisor_pkg::SHORT_FILTER_CYC,  // Short filter cycles
  parameter int DELAY_CYC = supervisor_pkg::RESET_DELAY_CYC    // Reset delay cycles
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   en_i,
  input  wire supervisor_pkg::cmp_s   cmp_i,
  input  wire supervisor_pkg::flags_s flag_clr_i,
  input  wire logic                   soft_reset_i,
  input  wire logic                   mode_req_valid_i,
  input  wire supervisor_pkg::mode_e  mode_req_i,
  input  wire logic                   aux_en_wr_i,
  input  wire logic [1:0]             aux_en_i,
  input  wire logic                   ext_en_wr_i,
  input  wire logic [1:0]             ext_en_i,
  input  wire logic                   hs_ctrl_wr_i,
  input  wire logic [3:0]             hs_ctrl_i,
  input  wire logic                   ov_rst_wr_i,
  input  wire logic                   ov_rst_i,
  input  wire logic                   ext_reg_keep_on_in_batt_uv_i,
  input  wire logic                   loadshare_stop_keep_on_i,
  input  wire logic                   loadshare_i,
  input  wire logic                   fail_out_clr_i,
  input  wire logic                   xcvr_fail_clr_i,
  output var  supervisor_pkg::mode_e  mode_o,
  output var  logic                   reset_output_n_o,
  output var  logic                   fail_outputs_o,
  output var  logic                   main_rail_on_o,
  output var  logic                   ext_reg_on_o,
  output var  logic [1:0]             aux_reg_enable_bits_o,
  output var  logic [1:0]             ext_reg_enable_bits_o,
  output var  logic [3:0]             highside_ctrl_o,
  output var  logic                   overvoltage_reset_enable_o,
  output var  logic                   tx_enable_o,
  output var  logic [1:0]             xcvr_fail_o,
  output var  logic [2:0]             uv_count_o,
  output var  supervisor_pkg::flags_s flags_o
);
  localparam int CW = supervisor_pkg::CNT_W;
  localparam logic [CW-1:0] SC_LAST = CW'(SHORT_CYC - 1);  // Last short-filter count
  localparam logic [CW-1:0] RD_LAST = CW'(DELAY_CYC - 1);  // Last reset-delay count

  // Whole state of the supervisor
  typedef struct packed {
    supervisor_pkg::cmp_s  s1;        // Synchroniser first stage
    supervisor_pkg::cmp_s  s2;        // Synchronised levels
    supervisor_pkg::cmp_s  s3;        // Previous levels for edges
    supervisor_pkg::mode_e mode;      // Operating mode
    logic                  rst_rel;   // Reset output released
    logic                  rail_on;   // Main rail switched on
    logic                  fail_out;  // Fail outputs active
    logic [CW-1:0]         dly;       // Reset delay counter
    logic [CW-1:0]         sc;        // Short filter counter
    logic [2:0]            uvc;       // Consecutive undervoltage count
    logic                  ov_rst;    // Overvoltage reset enable
    logic                  ov_pend;   // Restart caused by overvoltage
    logic [1:0]            aux_en;    // Aux regulator enables
    logic                  aux_chg;   // Aux enables just changed
    logic [1:0]            ext_en;    // Ext regulator enables
    logic                  ext_on;    // Ext regulator drive
    logic [3:0]            hs_ctrl;   // Highside control bits
    logic                  tx_en;     // Transmitter enabled
    logic [1:0]            xfail;     // Transceiver fail field
  } st_s;

  st_s                    q;          // Registered state
  st_s                    d;          // Next state
  supervisor_pkg::cmp_s   lvl;        // Synchronised levels
  supervisor_pkg::cmp_s   rise;       // Rising edges
  supervisor_pkg::flags_s set_v;      // Flag set requests
  supervisor_pkg::flags_s hold_v;     // Flag clear blockers
  supervisor_pkg::flags_s flags_q;    // Flag cell outputs
  logic                   uv_ev;      // Counted undervoltage event
  logic                   ov_fs;      // Overvoltage fail-safe entry
  logic                   sc_run;     // Short filter running

  // Next-state logic
  always_comb begin
    d      = q;
    set_v  = '0;
    hold_v = '0;
    uv_ev  = 1'b0;
    ov_fs  = 1'b0;
    sc_run = 1'b0;
    // Two-flop synchroniser, then edge history
    d.s1   = cmp_i;
    d.s2   = q.s1;
    d.s3   = q.s2;
    lvl    = q.s2;
    rise   = supervisor_pkg::cmp_s'(q.s2 & ~q.s3);

    // Host writes to control bits
    if (aux_en_wr_i) begin
      d.aux_en = aux_en_i;
    end
    if (ext_en_wr_i) begin
      d.ext_en = ext_en_i;
    end
    if (hs_ctrl_wr_i) begin
      d.hs_ctrl = hs_ctrl_i;
    end
    if (ov_rst_wr_i) begin
      d.ov_rst = ov_rst_i;
    end
    if (fail_out_clr_i) begin
      d.fail_out = 1'b0;
    end
    if (xcvr_fail_clr_i) begin
      d.xfail = supervisor_pkg::XCVR_FAIL_RST;
    end

    // Mode requests from the host
    if (mode_req_valid_i && (q.mode == supervisor_pkg::MODE_INIT ||
        q.mode == supervisor_pkg::MODE_NORMAL || q.mode == supervisor_pkg::MODE_STOP)) begin
      case (mode_req_i)
        supervisor_pkg::MODE_NORMAL,
        supervisor_pkg::MODE_STOP: begin
          d.mode = mode_req_i;
        end
        supervisor_pkg::MODE_SLEEP: begin
          if (q.mode != supervisor_pkg::MODE_INIT) begin
            d.mode    = supervisor_pkg::MODE_SLEEP;
            d.rail_on = 1'b0;
            d.rst_rel = 1'b0;
          end
        end
        default: begin
          d.mode = q.mode;
        end
      endcase
    end

    // Wake from sleep or fail-safe restarts the main rail
    if (lvl.wake && (q.mode == supervisor_pkg::MODE_SLEEP ||
        q.mode == supervisor_pkg::MODE_FAILSAFE)) begin
      d.mode    = supervisor_pkg::MODE_RESTART;
      d.rail_on = 1'b1;
      d.rst_rel = 1'b0;
      d.dly     = '0;
    end

    // Battery and highside supply flags
    set_v.battery_undervoltage_flag  = lvl.batt_uv;
    hold_v.battery_undervoltage_flag = lvl.batt_uv;
    set_v.highside_supply_uv_flag    = lvl.highside_uv;
    hold_v.highside_supply_uv_flag   = lvl.highside_uv;
    set_v.highside_supply_ov_flag    = lvl.highside_ov;
    hold_v.highside_supply_ov_flag   = lvl.highside_ov;

    // Counter clear by flag clear or soft reset
    if (flag_clr_i.main_rail_uv_flag || soft_reset_i) begin
      d.uvc = '0;
    end

    // Main-rail events, not while the rail is off
    if (q.rail_on && q.mode != supervisor_pkg::MODE_SLEEP) begin
      set_v.main_rail_warning_flag = rise.main_warn;
      if (rise.main_uv && q.mode != supervisor_pkg::MODE_FAILSAFE) begin
        set_v.main_rail_uv_flag = 1'b1;
        d.rst_rel = 1'b0;
        d.dly     = '0;
        uv_ev = (q.mode == supervisor_pkg::MODE_INIT ||
                 q.mode == supervisor_pkg::MODE_STOP ||
                 (q.mode == supervisor_pkg::MODE_NORMAL && !lvl.batt_uv));
        if (uv_ev && q.uvc + 3'h1 == supervisor_pkg::UV_FS_COUNT) begin
          d.mode = supervisor_pkg::MODE_FAILSAFE;
          set_v.repeated_uv_failsafe_flag = 1'b1;
        end else begin
          d.mode = supervisor_pkg::MODE_RESTART;
          if (uv_ev) begin
            d.uvc = q.uvc + 3'h1;
          end
        end
      end
    end

    // Main-rail overvoltage in init and normal
    if (rise.main_ov && (q.mode == supervisor_pkg::MODE_INIT ||
        q.mode == supervisor_pkg::MODE_NORMAL)) begin
      set_v.main_rail_ov_flag = 1'b1;
      if (q.ov_rst) begin
        d.fail_out = 1'b1;
        if (lvl.failsafe_config_pin) begin
          d.mode    = supervisor_pkg::MODE_RESTART;
          d.ov_pend = 1'b1;
          d.rst_rel = 1'b0;
          d.dly     = '0;
        end else begin
          d.mode = supervisor_pkg::MODE_FAILSAFE;
          ov_fs  = 1'b1;
        end
      end
    end

    // Reset delay once the rail is good, or after an overvoltage restart
    if ((q.mode == supervisor_pkg::MODE_INIT || q.mode == supervisor_pkg::MODE_RESTART) &&
        !q.rst_rel && d.mode == q.mode && (!lvl.main_uv || q.ov_pend)) begin
      if (q.dly == RD_LAST) begin
        d.rst_rel = 1'b1;
        d.dly     = '0;
        if (q.mode == supervisor_pkg::MODE_RESTART) begin
          d.mode = supervisor_pkg::MODE_NORMAL;
        end
        if (q.ov_pend) begin
          d.ov_pend = 1'b0;
          d.ov_rst  = 1'b0;
        end
      end else begin
        d.dly = q.dly + CW'(1);
      end
    end

    // Short filter, suspended during battery undervoltage
    sc_run = q.rail_on && lvl.main_uv && !lvl.batt_uv &&
             q.mode != supervisor_pkg::MODE_SLEEP &&
             q.mode != supervisor_pkg::MODE_FAILSAFE;
    if (sc_run) begin
      if (q.sc == SC_LAST) begin
        set_v.main_rail_short_flag = 1'b1;
        set_v.failure_flag         = 1'b1;
        d.rail_on  = 1'b0;
        d.fail_out = 1'b1;
        d.mode     = supervisor_pkg::MODE_FAILSAFE;
        d.sc       = '0;
      end else begin
        d.sc = q.sc + CW'(1);
      end
    end else begin
      d.sc = '0;
    end

    // Fail-safe entry bookkeeping
    if (d.mode == supervisor_pkg::MODE_FAILSAFE && q.mode != supervisor_pkg::MODE_FAILSAFE) begin
      d.uvc     = '0;
      d.rst_rel = 1'b0;
      d.ov_pend = 1'b0;
    end

    // Aux regulator overtemperature and undervoltage
    if (lvl.aux_ot && |q.aux_en) begin
      d.aux_en = 2'h0;
      set_v.aux_reg_overtemp_flag = 1'b1;
      set_v.block_overtemp_flag   = 1'b1;
    end
    d.aux_chg = (d.aux_en != q.aux_en);
    set_v.aux_reg_uv_flag = lvl.aux_uv && |q.aux_en && !q.aux_chg;
    set_v.transceiver_supply_uv_flag = lvl.xcvr_uv;

    // Ext regulator overtemperature
    if (lvl.ext_ot && |q.ext_en) begin
      set_v.ext_reg_overtemp_flag = 1'b1;
      if (!loadshare_i) begin
        d.ext_en = 2'h0;
      end
    end
    d.ext_on = |d.ext_en &&
               !(lvl.batt_uv && !ext_reg_keep_on_in_batt_uv_i) &&
               !(loadshare_i && d.mode == supervisor_pkg::MODE_STOP &&
                 !loadshare_stop_keep_on_i) &&
               !(loadshare_i && lvl.ext_ot);

    // Transceiver overtemperature: receive only
    d.tx_en = !lvl.xcvr_ot;
    if (lvl.xcvr_ot) begin
      d.xfail = supervisor_pkg::XCVR_FAIL_OT;
      set_v.block_overtemp_flag = 1'b1;
    end

    // Highside overtemperature turns all switches off
    if (|(lvl.highside_ot & q.hs_ctrl)) begin
      d.hs_ctrl = 4'h0;
      set_v.highside_oc_ot_flags = 4'hf;
      set_v.block_overtemp_flag  = 1'b1;
    end

    // Overtemperature flags clear only after cooling
    hold_v.block_overtemp_flag   = lvl.aux_ot | lvl.xcvr_ot | (|lvl.highside_ot);
    hold_v.aux_reg_overtemp_flag = lvl.aux_ot;
    hold_v.ext_reg_overtemp_flag = lvl.ext_ot;
    hold_v.highside_oc_ot_flags  = lvl.highside_ot;
  end

  // State register with clock enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q         <= '0;
      q.mode    <= supervisor_pkg::MODE_INIT;
      q.rail_on <= 1'b1;
      q.tx_en   <= supervisor_pkg::TX_EN_RST;
    end else if (en_i) begin
      q <= d;
    end
  end

  // One sticky cell per flag bit
  for (genvar i = 0; i < supervisor_pkg::FLAG_W; i++) begin : g_flag
    flag_cell u_flag (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .en_i    (en_i),
      .set_i   (set_v[i]),
      .clr_i   (flag_clr_i[i]),
      .hold_i  (hold_v[i]),
      .flag_o  (flags_q[i])
    );
  end

  // Outputs straight from state flops
  assign mode_o                     = q.mode;
  assign reset_output_n_o           = q.rst_rel;
  assign fail_outputs_o             = q.fail_out;
  assign main_rail_on_o             = q.rail_on;
  assign ext_reg_on_o               = q.ext_on;
  assign aux_reg_enable_bits_o      = q.aux_en;
  assign ext_reg_enable_bits_o      = q.ext_en;
  assign highside_ctrl_o            = q.hs_ctrl;
  assign overvoltage_reset_enable_o = q.ov_rst;
  assign tx_enable_o                = q.tx_en;
  assign xcvr_fail_o                = q.xfail;
  assign uv_count_o                 = q.uvc;
  assign flags_o                    = flags_q;

  // Checks, sampled on enabled edges only
  default clocking cb @(posedge clk_i iff en_i); endclocking
  default disable iff (!rst_n_i);

  property p_batt_flag;
    lvl.batt_uv |=> flags_o.battery_undervoltage_flag;
  endproperty
  a_batt_flag: assert property (p_batt_flag) else $error("battery flag missing");

  property p_ext_off;
    lvl.batt_uv && !ext_reg_keep_on_in_batt_uv_i |=> !ext_reg_on_o;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext regulator on in uv");

  property p_sc_hold;
    lvl.batt_uv |=> q.sc == '0;
  endproperty
  a_sc_hold: assert property (p_sc_hold) else $error("short filter ran in uv");

  property p_uv_reset;
    q.rail_on && rise.main_uv && q.mode != supervisor_pkg::MODE_SLEEP &&
      q.mode != supervisor_pkg::MODE_FAILSAFE
      |=> !reset_output_n_o && flags_o.main_rail_uv_flag;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("uv did not reset");

  property p_uv_fs;
    uv_ev && q.uvc == 3'h3 |=> mode_o == supervisor_pkg::MODE_FAILSAFE &&
      flags_o.repeated_uv_failsafe_flag && uv_count_o == 3'h0;
  endproperty
  a_uv_fs: assert property (p_uv_fs) else $error("fourth uv not fail-safe");

  property p_ov_flag;
    rise.main_ov && (q.mode == supervisor_pkg::MODE_INIT ||
      q.mode == supervisor_pkg::MODE_NORMAL) |=> flags_o.main_rail_ov_flag;
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("ov flag missing");

  property p_ov_back;
    q.ov_pend && q.mode == supervisor_pkg::MODE_RESTART && q.dly == RD_LAST &&
      !q.rst_rel && !sc_run |=> mode_o == supervisor_pkg::MODE_NORMAL &&
      reset_output_n_o && !overvoltage_reset_enable_o;
  endproperty
  a_ov_back: assert property (p_ov_back) else $error("ov restart did not end");

  property p_ov_fs;
    ov_fs |=> mode_o == supervisor_pkg::MODE_FAILSAFE && fail_outputs_o;
  endproperty
  a_ov_fs: assert property (p_ov_fs) else $error("ov fail-safe missing");

  property p_short;
    sc_run && q.sc == SC_LAST |=> !main_rail_on_o && flags_o.main_rail_short_flag &&
      flags_o.failure_flag && mode_o == supervisor_pkg::MODE_FAILSAFE;
  endproperty
  a_short: assert property (p_short) else $error("short not handled");

  property p_hs_ot;
    |(lvl.highside_ot & q.hs_ctrl) |=> highside_ctrl_o == 4'h0 &&
      flags_o.highside_oc_ot_flags == 4'hf && flags_o.block_overtemp_flag;
  endproperty
  a_hs_ot: assert property (p_hs_ot) else $error("highside ot not handled");

  property p_xcvr_ot;
    lvl.xcvr_ot |=> !tx_enable_o && xcvr_fail_o == supervisor_pkg::XCVR_FAIL_OT;
  endproperty
  a_xcvr_ot: assert property (p_xcvr_ot) else $error("transceiver ot not handled");

  // Main scenarios reached
  c_uv_fs: cover property (uv_ev && q.uvc == 3'h3);
  c_ov_rst: cover property (q.ov_pend ##1 !q.ov_pend);
  c_short: cover property (sc_run && q.sc == SC_LAST);
endmodule  // supply_thermal_fault_supervisor
`default_nettype wire

/* supply_thermal_fault_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_thermal_fault_supervisor_tb;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
  localparam int DLY = 16;                // Shortened reset delay
  int                     errors    = 0;  // Mismatch count
  int                     tests_run = 0;  // Comparison count
  logic                   clk_i     = 1'b0;
  logic                   rst_n_i   = 1'b0;
  logic                   req = 1'b0, mreq = 1'b0, ow = 1'b0, ovb = 1'b0;
  logic                   aw = 1'b0, ew = 1'b0, hw = 1'b0, foc = 1'b0;
  logic                   en = 1'b1, sr = 1'b0, kb = 1'b0, ls = 1'b0;
  supervisor_pkg::cmp_s   cmp       = '0; // Comparator levels
  supervisor_pkg::flags_s mask = '0, clr, fl, ex;
  supervisor_pkg::mode_e  mode, mr = supervisor_pkg::MODE_NORMAL;
  logic                   ro_n, fo, rail, ext_on, ovr, tx;
  logic [1:0]             auxb, extb, xf;
  logic [3:0]             hs;
  logic [2:0]             cnt;
  // Free-running 20 MHz clock
  always #25 clk_i = ~clk_i;
  host_model host_model_inst (.clk_i(clk_i), .clr_req_i(req), .clr_mask_i(mask),
    .flag_clr_o(clr));
  supply_thermal_fault_supervisor #(.SHORT_CYC(8), .DELAY_CYC(DLY))
    supply_thermal_fault_supervisor_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .cmp_i(cmp), .flag_clr_i(clr),
    .soft_reset_i(sr), .mode_req_valid_i(mreq), .mode_req_i(mr),
    .aux_en_wr_i(aw), .aux_en_i(2'h3), .ext_en_wr_i(ew), .ext_en_i(2'h3),
    .hs_ctrl_wr_i(hw), .hs_ctrl_i(4'hf), .ov_rst_wr_i(ow), .ov_rst_i(ovb),
    .ext_reg_keep_on_in_batt_uv_i(kb), .loadshare_stop_keep_on_i(1'b0),
    .loadshare_i(ls), .fail_out_clr_i(foc), .xcvr_fail_clr_i(1'b0), .mode_o(mode),
    .reset_output_n_o(ro_n), .fail_outputs_o(fo), .main_rail_on_o(rail),
    .ext_reg_on_o(ext_on), .aux_reg_enable_bits_o(auxb), .ext_reg_enable_bits_o(extb),
    .highside_ctrl_o(hs), .overvoltage_reset_enable_o(ovr), .tx_enable_o(tx),
    .xcvr_fail_o(xf), .uv_count_o(cnt), .flags_o(fl));
  // Advance n edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Host clear of the flags in m
  task automatic clear(input supervisor_pkg::flags_s m);
    mask = m;
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(2);
  endtask
  // Bounded wait for a mode
  task automatic wait_mode(input supervisor_pkg::mode_e m);
    for (int i = 0; i < 200 && mode !== m; i++) step(1);
    if (mode !== m) begin
      errors++;
      summarize();
    end
  endtask
  // Wake out of fail-safe back to normal
  task automatic recover();
    cmp.wake = 1'b1;
    step(4);
    cmp.wake = 1'b0;
    `CHK(rail, 1'b1)
    wait_mode(supervisor_pkg::MODE_NORMAL);
    foc = 1'b1;
    step(1);
    foc = 1'b0;
    clear('1);
  endtask
  // Battery and highside supply events set one flag each
  task automatic t_supply();
    ew = 1'b1;
    step(1);
    ew = 1'b0;
    cmp.batt_uv = 1'b1;
    step(4);
    ex = '0;
    ex.battery_undervoltage_flag = 1'b1;
    `CHK(fl, ex)
    `CHK(ext_on, 1'b0)
    clear(ex);
    `CHK(fl, ex)
    cmp.batt_uv = 1'b0;
    step(4);
    `CHK(ext_on, 1'b1)
    clear(ex);
    cmp.highside_uv = 1'b1;
    step(4);
    ex = '0;
    ex.highside_supply_uv_flag = 1'b1;
    `CHK(fl, ex)
    `CHK({mode, rail, ro_n}, {supervisor_pkg::MODE_NORMAL, 2'h3})
    cmp = '0;
    step(4);
    clear(ex);
    cmp.highside_ov = 1'b1;
    step(4);
    ex = '0;
    ex.highside_supply_ov_flag = 1'b1;
    `CHK(fl, ex)
    cmp = '0;
    step(4);
    clear(ex);
    `CHK(fl, '0)
  endtask
  // Four undervoltage events in a row end in fail-safe
  task automatic t_uv();
    for (int k = 1; k <= 4; k++) begin
      cmp.main_uv = 1'b1;
      step(4);
      cmp.main_uv = 1'b0;
      `CHK(ro_n, 1'b0)
      `CHK(fl.main_rail_uv_flag, 1'b1)
      `CHK(cnt, (k < 4) ? k[2:0] : 3'h0)
      `CHK(mode, (k < 4) ? supervisor_pkg::MODE_RESTART : supervisor_pkg::MODE_FAILSAFE)
      if (k < 4) wait_mode(supervisor_pkg::MODE_NORMAL);
    end
    `CHK(fl.repeated_uv_failsafe_flag, 1'b1)
    recover();
  endtask
  // Overvoltage with restart for pin one, with fail-safe for pin zero
  task automatic t_ov(input logic pin);
    ovb = 1'b1;
    ow = 1'b1;
    step(1);
    ow = 1'b0;
    cmp.failsafe_config_pin = pin;
    cmp.main_ov = 1'b1;
    step(4);
    cmp.main_ov = 1'b0;
    `CHK(fl.main_rail_ov_flag, 1'b1)
    `CHK(fo, 1'b1)
    `CHK(mode, pin ? supervisor_pkg::MODE_RESTART : supervisor_pkg::MODE_FAILSAFE)
    if (pin) wait_mode(supervisor_pkg::MODE_NORMAL);
    if (pin) `CHK(ovr, 1'b0)
    recover();
  endtask
  // Rail held low past the filter time
  task automatic t_short();
    cmp.main_uv = 1'b1;
    step(16);
    cmp.main_uv = 1'b0;
    `CHK({fl.main_rail_short_flag, fl.failure_flag, rail, fo}, 4'hd)
    `CHK(mode, supervisor_pkg::MODE_FAILSAFE)
    recover();
  endtask
  // Overtemperature of aux, transceiver and highside stages
  task automatic t_ot();
    {aw, hw} = 2'h3;
    step(1);
    {aw, hw} = 2'h0;
    cmp.highside_ot = 4'h2;
    cmp.aux_ot = 1'b1;
    cmp.xcvr_ot = 1'b1;
    step(4);
    `CHK({hs, fl.highside_oc_ot_flags}, 8'h0f)
    `CHK({auxb, fl.aux_reg_overtemp_flag, fl.block_overtemp_flag}, 4'h3)
    `CHK({tx, xf}, 3'h1)
    clear('1);
    `CHK(fl.block_overtemp_flag, 1'b1)
    cmp = '0;
    step(4);
    `CHK(tx, 1'b1)
  endtask
  // Keep bits, load sharing, stop mode, soft reset and clock enable
  task automatic t_cfg();
    {ls, kb} = 2'h3;
    cmp.batt_uv = 1'b1;
    step(4);
    `CHK(ext_on, 1'b1)
    cmp.ext_ot = 1'b1;
    step(4);
    `CHK({ext_on, extb, fl.ext_reg_overtemp_flag}, 4'h7)
    cmp = '0;
    step(4);
    `CHK(ext_on, 1'b1)
    ovb = 1'b0;
    ow = 1'b1;
    step(1);
    ow = 1'b0;
    `CHK(ovr, 1'b0)
    mr = supervisor_pkg::MODE_STOP;
    mreq = 1'b1;
    step(1);
    mreq = 1'b0;
    `CHK({mode, ext_on}, {supervisor_pkg::MODE_STOP, 1'b0})
    cmp.main_uv = 1'b1;
    step(4);
    cmp.main_uv = 1'b0;
    `CHK({mode, cnt}, {supervisor_pkg::MODE_RESTART, 3'h1})
    sr = 1'b1;
    step(1);
    sr = 1'b0;
    `CHK(cnt, 3'h0)
    wait_mode(supervisor_pkg::MODE_NORMAL);
    clear('1);
    en = 1'b0;
    {cmp.batt_uv, cmp.main_warn, cmp.xcvr_uv} = 3'h7;
    step(4);
    `CHK(fl, '0)
    en = 1'b1;
    step(4);
    ex = '0;
    {ex.battery_undervoltage_flag, ex.main_rail_warning_flag} = 2'h3;
    ex.transceiver_supply_uv_flag = 1'b1;
    `CHK(fl, ex)
    cmp = '0;
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    step(8);
    rst_n_i = 1'b1;
    step(DLY + 6);
    mreq = 1'b1;
    step(1);
    mreq = 1'b0;
    wait_mode(supervisor_pkg::MODE_NORMAL);
    t_supply();
    t_uv();
    t_ov(1'b1);
    t_ov(1'b0);
    t_short();
    t_ot();
    t_cfg();
    summarize();
  end
endmodule // supply_thermal_fault_supervisor_tb
`default_nettype wire
